// File: rtl/port_pin_defines.vh
// constants for the port pin configuration and over-current block
`ifndef PORT_PIN_DEFINES_VH
`define PORT_PIN_DEFINES_VH

// ************************************************************
// register offsets
// ************************************************************
`define ADDR_W 10
`define OFS_OVERCURRENT_DETECT_ENABLE 10'h2_F8
`define OFS_OVERCURRENT_IRQ_ENABLE 10'h2_F9
`define OFS_OVERCURRENT_FLAG 10'h2_FA
`define OFS_DIGITAL_INPUT_ENABLE 10'h2_FC
`define OFS_PORT_REDUCED_DRIVE 10'h2_FD
`define OFS_WIRED_OR_MODE 10'h2_FE

// ************************************************************
// reset values
// ************************************************************
`define RST_DIGITAL_INPUT_ENABLE 8'h00
`define RST_PORT_REDUCED_DRIVE 8'h00
`define RST_WIRED_OR_MODE 8'h00
`define RST_OVERCURRENT_DETECT_ENABLE 8'h00
`define RST_OVERCURRENT_IRQ_ENABLE 8'h00
`define RST_OVERCURRENT_FLAG 8'h00
`define RESERVED_READ_VALUE 8'h00

// ************************************************************
// over-current field positions
// ************************************************************
`define BIT_SUPPLY 7
`define BIT_HS_PIN5 5
`define BIT_HS_PIN3 3
`define BIT_HS_PIN1 1
`define OC_FIELD_MASK 8'hA_A

`endif

// File: rtl/level_sync3.v
// three-stage synchroniser with agreement filter for one level input
`timescale 1ns/10ps
`default_nettype none
module level_sync3
#(
  parameter RESET_LEVEL = 1'b0
)
(
  input wire clk_in,
  input wire rstn_in,
  input wire async_in,
  output reg level_out
);

  reg stage1_reg;
  reg stage2_reg;
  reg stage3_reg;

  // stage1 feeds stage2 only; change counts once stage2 and stage3 agree
  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      stage1_reg <= RESET_LEVEL;
      stage2_reg <= RESET_LEVEL;
      stage3_reg <= RESET_LEVEL;
      level_out <= RESET_LEVEL;
    end
    else
    begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      if (stage2_reg == stage3_reg)
      begin
        level_out <= stage3_reg;
      end
    end
  end

endmodule
`default_nettype wire

// File: rtl/port_pin_config_overcurrent.v
// port pin configuration registers and supply and high-side over-current flags
//
// Our own choice: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "port_pin_defines.vh"
module port_pin_config_overcurrent
#(
  parameter PIN_COUNT = 8
)
(
  input wire CLK_IN,
  input wire RSTN_IN,
  input wire [`ADDR_W-1:0] ADDR_IN,
  input wire [7:0] WDATA_IN,
  input wire WR_IN,
  input wire RD_IN,
  output reg [7:0] RDATA_OUT,
  input wire [PIN_COUNT-1:0] PERIPH_DIGITAL_USE_IN,
  input wire [PIN_COUNT-1:0] PIN_IS_OUTPUT_IN,
  input wire [PIN_COUNT-1:0] PIN_DATA_IN,
  output reg [PIN_COUNT-1:0] INPUT_BUFFER_EN_OUT,
  output reg [PIN_COUNT-1:0] REDUCED_DRIVE_OUT,
  output reg [PIN_COUNT-1:0] HIGH_DRIVE_OFF_OUT,
  output reg [PIN_COUNT-1:0] PAD_O_OUT,
  output reg [PIN_COUNT-1:0] PAD_OE_OUT,
  input wire SUPPLY_OVERCURRENT_IN,
  input wire HS_PIN5_OVERCURRENT_IN,
  input wire HS_PIN3_OVERCURRENT_IN,
  input wire HS_PIN1_OVERCURRENT_IN,
  output reg SUPPLY_DETECT_EN_OUT,
  output reg HS_PIN5_DETECT_EN_OUT,
  output reg HS_PIN3_DETECT_EN_OUT,
  output reg HS_PIN1_DETECT_EN_OUT,
  output reg IRQ_OUT
);

  // ************************************************************
  // registers and next values
  // ************************************************************
  reg [PIN_COUNT-1:0] input_buffer_enable_bits_reg;
  reg [PIN_COUNT-1:0] input_buffer_enable_bits_next;
  reg [PIN_COUNT-1:0] reduced_drive_bits_reg;
  reg [PIN_COUNT-1:0] reduced_drive_bits_next;
  reg [PIN_COUNT-1:0] open_drain_select_bits_reg;
  reg [PIN_COUNT-1:0] open_drain_select_bits_next;
  reg [7:0] overcurrent_detect_enable_reg;
  reg [7:0] overcurrent_detect_enable_next;
  reg [7:0] overcurrent_irq_enable_reg;
  reg [7:0] overcurrent_irq_enable_next;
  reg [7:0] overcurrent_flag_reg;
  reg [7:0] overcurrent_flag_next;
  reg [7:0] rdata_next;
  reg [7:0] read_mux;
  reg [PIN_COUNT-1:0] input_buffer_en_next;
  reg [PIN_COUNT-1:0] reduced_drive_out_next;
  reg [PIN_COUNT-1:0] high_drive_off_next;
  reg [PIN_COUNT-1:0] pad_o_next;
  reg [PIN_COUNT-1:0] pad_oe_next;
  reg [3:0] detect_en_next;
  reg irq_next;

  wire sel_detect_enable;
  wire sel_irq_enable;
  wire sel_flag;
  wire sel_input_enable;
  wire sel_reduced_drive;
  wire sel_open_drain;
  wire supply_oc_level;
  wire hs_pin5_oc_level;
  wire hs_pin3_oc_level;
  wire hs_pin1_oc_level;
  wire [7:0] oc_event;
  wire supply_oc_event;
  wire hs_pin5_oc_event;
  wire hs_pin3_oc_event;
  wire hs_pin1_oc_event;

  // ************************************************************
  // address decode
  // ************************************************************
  assign sel_detect_enable = (ADDR_IN == `OFS_OVERCURRENT_DETECT_ENABLE);
  assign sel_irq_enable = (ADDR_IN == `OFS_OVERCURRENT_IRQ_ENABLE);
  assign sel_flag = (ADDR_IN == `OFS_OVERCURRENT_FLAG);
  assign sel_input_enable = (ADDR_IN == `OFS_DIGITAL_INPUT_ENABLE);
  assign sel_reduced_drive = (ADDR_IN == `OFS_PORT_REDUCED_DRIVE);
  assign sel_open_drain = (ADDR_IN == `OFS_WIRED_OR_MODE);

  // ************************************************************
  // detector input synchronisers
  // ************************************************************
  level_sync3 #(.RESET_LEVEL(1'b0)) sync_supply
  (
    .clk_in(CLK_IN),
    .rstn_in(RSTN_IN),
    .async_in(SUPPLY_OVERCURRENT_IN),
    .level_out(supply_oc_level)
  );

  level_sync3 #(.RESET_LEVEL(1'b0)) sync_hs_pin5
  (
    .clk_in(CLK_IN),
    .rstn_in(RSTN_IN),
    .async_in(HS_PIN5_OVERCURRENT_IN),
    .level_out(hs_pin5_oc_level)
  );

  level_sync3 #(.RESET_LEVEL(1'b0)) sync_hs_pin3
  (
    .clk_in(CLK_IN),
    .rstn_in(RSTN_IN),
    .async_in(HS_PIN3_OVERCURRENT_IN),
    .level_out(hs_pin3_oc_level)
  );

  level_sync3 #(.RESET_LEVEL(1'b0)) sync_hs_pin1
  (
    .clk_in(CLK_IN),
    .rstn_in(RSTN_IN),
    .async_in(HS_PIN1_OVERCURRENT_IN),
    .level_out(hs_pin1_oc_level)
  );

  // a report only counts while its detector is switched on
  assign supply_oc_event = supply_oc_level & overcurrent_detect_enable_reg[`BIT_SUPPLY];
  assign hs_pin5_oc_event = hs_pin5_oc_level & overcurrent_detect_enable_reg[`BIT_HS_PIN5];
  assign hs_pin3_oc_event = hs_pin3_oc_level & overcurrent_detect_enable_reg[`BIT_HS_PIN3];
  assign hs_pin1_oc_event = hs_pin1_oc_level & overcurrent_detect_enable_reg[`BIT_HS_PIN1];
  assign oc_event = {supply_oc_event, 1'b0, hs_pin5_oc_event, 1'b0, hs_pin3_oc_event, 1'b0,
    hs_pin1_oc_event, 1'b0};

  // ************************************************************
  // register write logic
  // ************************************************************
  always @*
  begin
    input_buffer_enable_bits_next = input_buffer_enable_bits_reg;
    reduced_drive_bits_next = reduced_drive_bits_reg;
    open_drain_select_bits_next = open_drain_select_bits_reg;
    overcurrent_detect_enable_next = overcurrent_detect_enable_reg;
    overcurrent_irq_enable_next = overcurrent_irq_enable_reg;
    overcurrent_flag_next = overcurrent_flag_reg;
    if (WR_IN)
    begin
      if (sel_input_enable)
      begin
        input_buffer_enable_bits_next = WDATA_IN[PIN_COUNT-1:0];
      end
      if (sel_reduced_drive)
      begin
        reduced_drive_bits_next = WDATA_IN[PIN_COUNT-1:0];
      end
      if (sel_open_drain)
      begin
        open_drain_select_bits_next = WDATA_IN[PIN_COUNT-1:0];
      end
      if (sel_detect_enable)
      begin
        overcurrent_detect_enable_next = WDATA_IN & `OC_FIELD_MASK;
      end
      if (sel_irq_enable)
      begin
        overcurrent_irq_enable_next = WDATA_IN & `OC_FIELD_MASK;
      end
      if (sel_flag)
      begin
        overcurrent_flag_next = overcurrent_flag_reg & ~WDATA_IN;
      end
    end
    // a detector report wins over a clear in the same cycle
    overcurrent_flag_next = (overcurrent_flag_next | oc_event) & `OC_FIELD_MASK;
  end

  // ************************************************************
  // read mux
  // ************************************************************
  always @*
  begin
    read_mux = `RESERVED_READ_VALUE;
    if (sel_input_enable)
    begin
      read_mux = input_buffer_enable_bits_reg;
    end
    else if (sel_reduced_drive)
    begin
      read_mux = reduced_drive_bits_reg;
    end
    else if (sel_open_drain)
    begin
      read_mux = open_drain_select_bits_reg;
    end
    else if (sel_detect_enable)
    begin
      read_mux = overcurrent_detect_enable_reg;
    end
    else if (sel_irq_enable)
    begin
      read_mux = overcurrent_irq_enable_reg;
    end
    else if (sel_flag)
    begin
      read_mux = overcurrent_flag_reg;
    end
    rdata_next = RD_IN ? read_mux : 8'h0_0;
  end

  // ************************************************************
  // state registers
  // ************************************************************
  always @(posedge CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      input_buffer_enable_bits_reg <= `RST_DIGITAL_INPUT_ENABLE;
      reduced_drive_bits_reg <= `RST_PORT_REDUCED_DRIVE;
      open_drain_select_bits_reg <= `RST_WIRED_OR_MODE;
      overcurrent_detect_enable_reg <= `RST_OVERCURRENT_DETECT_ENABLE;
      overcurrent_irq_enable_reg <= `RST_OVERCURRENT_IRQ_ENABLE;
      overcurrent_flag_reg <= `RST_OVERCURRENT_FLAG;
      RDATA_OUT <= 8'h0_0;
    end
    else
    begin
      input_buffer_enable_bits_reg <= input_buffer_enable_bits_next;
      reduced_drive_bits_reg <= reduced_drive_bits_next;
      open_drain_select_bits_reg <= open_drain_select_bits_next;
      overcurrent_detect_enable_reg <= overcurrent_detect_enable_next;
      overcurrent_irq_enable_reg <= overcurrent_irq_enable_next;
      overcurrent_flag_reg <= overcurrent_flag_next;
      RDATA_OUT <= rdata_next;
    end
  end

  // ************************************************************
  // pin control next values
  // ************************************************************
  always @*
  begin
    input_buffer_en_next = input_buffer_enable_bits_reg | PERIPH_DIGITAL_USE_IN;
    reduced_drive_out_next = reduced_drive_bits_reg & PIN_IS_OUTPUT_IN;
    high_drive_off_next = open_drain_select_bits_reg & PIN_IS_OUTPUT_IN;
    pad_o_next = PIN_DATA_IN;
    // open-drain pins drive only while pulling low
    pad_oe_next = PIN_IS_OUTPUT_IN & (~open_drain_select_bits_reg | ~PIN_DATA_IN);
  end

  // ************************************************************
  // pin control outputs
  // ************************************************************
  always @(posedge CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      INPUT_BUFFER_EN_OUT <= {PIN_COUNT{1'b0}};
      REDUCED_DRIVE_OUT <= {PIN_COUNT{1'b0}};
      HIGH_DRIVE_OFF_OUT <= {PIN_COUNT{1'b0}};
      PAD_O_OUT <= {PIN_COUNT{1'b0}};
      PAD_OE_OUT <= {PIN_COUNT{1'b0}};
    end
    else
    begin
      INPUT_BUFFER_EN_OUT <= input_buffer_en_next;
      REDUCED_DRIVE_OUT <= reduced_drive_out_next;
      HIGH_DRIVE_OFF_OUT <= high_drive_off_next;
      PAD_O_OUT <= pad_o_next;
      PAD_OE_OUT <= pad_oe_next;
    end
  end

  // ************************************************************
  // detector enable and interrupt next values
  // ************************************************************
  always @*
  begin
    detect_en_next[3] = overcurrent_detect_enable_next[`BIT_SUPPLY];
    detect_en_next[2] = overcurrent_detect_enable_next[`BIT_HS_PIN5];
    detect_en_next[1] = overcurrent_detect_enable_next[`BIT_HS_PIN3];
    detect_en_next[0] = overcurrent_detect_enable_next[`BIT_HS_PIN1];
    // request stands while any unmasked flag is set
    irq_next = |(overcurrent_flag_next & overcurrent_irq_enable_next);
  end

  // ************************************************************
  // detector enables and interrupt
  // ************************************************************
  always @(posedge CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      SUPPLY_DETECT_EN_OUT <= 1'b0;
      HS_PIN5_DETECT_EN_OUT <= 1'b0;
      HS_PIN3_DETECT_EN_OUT <= 1'b0;
      HS_PIN1_DETECT_EN_OUT <= 1'b0;
      IRQ_OUT <= 1'b0;
    end
    else
    begin
      SUPPLY_DETECT_EN_OUT <= detect_en_next[3];
      HS_PIN5_DETECT_EN_OUT <= detect_en_next[2];
      HS_PIN3_DETECT_EN_OUT <= detect_en_next[1];
      HS_PIN1_DETECT_EN_OUT <= detect_en_next[0];
      IRQ_OUT <= irq_next;
    end
  end

endmodule
`default_nettype wire

// File: bench/port_pin_config_overcurrent_sva.sv
// checker for the port pin configuration and over-current block
`timescale 1ns/10ps
`default_nettype none
`include "port_pin_defines.vh"
module port_pin_config_overcurrent_chk
#(
  parameter PIN_COUNT = 8
)
(
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic [`ADDR_W-1:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [7:0] RDATA_OUT,
  input wire logic [PIN_COUNT-1:0] PERIPH_DIGITAL_USE_IN,
  input wire logic [PIN_COUNT-1:0] PIN_IS_OUTPUT_IN,
  input wire logic [PIN_COUNT-1:0] INPUT_BUFFER_EN_OUT,
  input wire logic [PIN_COUNT-1:0] REDUCED_DRIVE_OUT,
  input wire logic [PIN_COUNT-1:0] HIGH_DRIVE_OFF_OUT,
  input wire logic [PIN_COUNT-1:0] PAD_O_OUT,
  input wire logic [PIN_COUNT-1:0] PAD_OE_OUT,
  input wire logic SUPPLY_DETECT_EN_OUT,
  input wire logic HS_PIN5_DETECT_EN_OUT,
  input wire logic HS_PIN3_DETECT_EN_OUT,
  input wire logic HS_PIN1_DETECT_EN_OUT,
  input wire logic IRQ_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  logic [3:0] det_en;
  assign det_en = {SUPPLY_DETECT_EN_OUT, HS_PIN5_DETECT_EN_OUT, HS_PIN3_DETECT_EN_OUT,
    HS_PIN1_DETECT_EN_OUT};
  property p_rdata_idle;
    !$past(RD_IN) |-> RDATA_OUT == 8'h00;
  endproperty
  property p_rsvd;
    RD_IN && ADDR_IN == 10'h2FB |=> RDATA_OUT == 8'h00;
  endproperty
  property p_ibuf;
    ($past(PERIPH_DIGITAL_USE_IN) & ~INPUT_BUFFER_EN_OUT) == 0;
  endproperty
  property p_rdr_in;
    (REDUCED_DRIVE_OUT & ~$past(PIN_IS_OUTPUT_IN)) == 0;
  endproperty
  property p_od_in;
    ((HIGH_DRIVE_OFF_OUT | PAD_OE_OUT) & ~$past(PIN_IS_OUTPUT_IN)) == 0;
  endproperty
  property p_od_high;
    (HIGH_DRIVE_OFF_OUT & PAD_OE_OUT & PAD_O_OUT) == 0;
  endproperty
  property p_det_en;
    WR_IN && ADDR_IN == `OFS_OVERCURRENT_DETECT_ENABLE
      |=> det_en == $past({WDATA_IN[7], WDATA_IN[5], WDATA_IN[3], WDATA_IN[1]});
  endproperty
  property p_irq_mask;
    WR_IN && ADDR_IN == `OFS_OVERCURRENT_IRQ_ENABLE && WDATA_IN == 8'h00 |=> !IRQ_OUT;
  endproperty
  property p_irq_clear;
    WR_IN && ADDR_IN == `OFS_OVERCURRENT_FLAG && WDATA_IN == 8'hFF && det_en == 0
      |=> !IRQ_OUT [*2];
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
  a_rsvd: assert property (p_rsvd) else $error("reserved read not zero");
  a_ibuf: assert property (p_ibuf) else $error("input buffer not forced");
  a_rdr_in: assert property (p_rdr_in) else $error("reduced drive on input");
  a_od_in: assert property (p_od_in) else $error("output control on input");
  a_od_high: assert property (p_od_high) else $error("open drain drives high");
  a_det_en: assert property (p_det_en) else $error("detector enable wrong");
  a_irq_mask: assert property (p_irq_mask) else $error("masked irq high");
  a_irq_clear: assert property (p_irq_clear) else $error("irq after clear");
  c_irq: cover property (IRQ_OUT);
  c_read: cover property (RD_IN ##1 RDATA_OUT != 8'h00);
  c_od: cover property (|HIGH_DRIVE_OFF_OUT);
endmodule
`default_nettype wire

// File: bench/pin_load_model.sv
// pin loads with pull-ups and over-current fault sources
`timescale 1ns/10ps
`default_nettype none
module pin_load_model
(
  input wire logic [7:0] pad_o_in,
  input wire logic [7:0] pad_oe_in,
  input wire logic [3:0] det_en_in,
  input wire logic [3:0] fault_in,
  output logic [7:0] level_out,
  output logic [3:0] report_out
);
  // released pins are pulled up
  assign level_out = (pad_oe_in & pad_o_in) | ~pad_oe_in;
  // a detector only reports while switched on
  assign report_out = fault_in & det_en_in;
endmodule
`default_nettype wire

// File: bench/port_pin_config_overcurrent_tb_top.sv
// testbench for the port pin configuration and over-current block
`timescale 1ns/10ps
`default_nettype none
`include "port_pin_defines.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected %0t got %h exp %h", $time, g, e); end end
module port_pin_config_overcurrent_tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [9:0] addr = '0;
  logic [7:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] periph = '0, is_out = '0, pdata = '0, b;
  logic [7:0] rdata, ibuf, rdr, hoff, pad_o, pad_oe, level;
  logic [3:0] fault = '0;
  wire [3:0] det_en;
  wire [3:0] report;
  logic irq;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [9:0] regs [6] = '{`OFS_OVERCURRENT_DETECT_ENABLE, `OFS_OVERCURRENT_IRQ_ENABLE,
    `OFS_OVERCURRENT_FLAG, `OFS_DIGITAL_INPUT_ENABLE, `OFS_PORT_REDUCED_DRIVE,
    `OFS_WIRED_OR_MODE};
  logic [7:0] back [6] = '{8'h0A, 8'h0A, 8'h00, 8'h5F, 8'h5F, 8'h5F};
  always #50 clk = ~clk;
  port_pin_config_overcurrent dut_u (.CLK_IN(clk), .RSTN_IN(rstn), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
    .PERIPH_DIGITAL_USE_IN(periph), .PIN_IS_OUTPUT_IN(is_out), .PIN_DATA_IN(pdata),
    .INPUT_BUFFER_EN_OUT(ibuf), .REDUCED_DRIVE_OUT(rdr), .HIGH_DRIVE_OFF_OUT(hoff),
    .PAD_O_OUT(pad_o), .PAD_OE_OUT(pad_oe), .SUPPLY_OVERCURRENT_IN(report[3]),
    .HS_PIN5_OVERCURRENT_IN(report[2]), .HS_PIN3_OVERCURRENT_IN(report[1]),
    .HS_PIN1_OVERCURRENT_IN(report[0]), .SUPPLY_DETECT_EN_OUT(det_en[3]),
    .HS_PIN5_DETECT_EN_OUT(det_en[2]), .HS_PIN3_DETECT_EN_OUT(det_en[1]),
    .HS_PIN1_DETECT_EN_OUT(det_en[0]), .IRQ_OUT(irq));
  pin_load_model load_u (.pad_o_in(pad_o), .pad_oe_in(pad_oe), .det_en_in(det_en),
    .fault_in(fault), .level_out(level), .report_out(report));
  task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [9:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      n_mismatch++;
      summarize();
    end
  end
  initial
  begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 6; i++)
      rd_reg(regs[i], 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      wr_reg(regs[i], 8'h5F);
      rd_reg(regs[i], back[i]);
    end
    wr_reg(10'h2FB, 8'hFF);
    rd_reg(10'h2FB, 8'h00);
    rd_reg(10'h2FF, 8'h00);
    rd_reg(`OFS_WIRED_OR_MODE, 8'h5F);
    // upper four pins on analog duty
    wr_reg(`OFS_DIGITAL_INPUT_ENABLE, 8'h0F);
    wr_reg(`OFS_PORT_REDUCED_DRIVE, 8'hF0);
    wr_reg(`OFS_WIRED_OR_MODE, 8'hCC);
    periph <= 8'h30;
    is_out <= 8'h55;
    pdata <= 8'h0F;
    repeat (2) @(posedge clk);
    #1;
    `CHK(ibuf, 8'h3F)
    `CHK(rdr, 8'h50)
    `CHK(hoff, 8'h44)
    `CHK(pad_oe, 8'h51)
    `CHK(level, 8'hAF)
    for (int k = 0; k < 4; k++)
    begin
      b = 8'h02 << (2 * k);
      wr_reg(`OFS_OVERCURRENT_DETECT_ENABLE, b);
      #1;
      `CHK(det_en, 4'b0001 << k)
      wr_reg(`OFS_OVERCURRENT_IRQ_ENABLE, b);
      fault <= 4'b0001 << k;
      repeat (8) @(posedge clk);
      #1;
      `CHK(irq, 1'b1)
      rd_reg(`OFS_OVERCURRENT_FLAG, b);
      wr_reg(`OFS_OVERCURRENT_IRQ_ENABLE, 8'h00);
      #1;
      `CHK(irq, 1'b0)
      wr_reg(`OFS_OVERCURRENT_IRQ_ENABLE, b);
      fault <= 4'b0000;
      repeat (6) @(posedge clk);
      wr_reg(`OFS_OVERCURRENT_DETECT_ENABLE, 8'h00);
      wr_reg(`OFS_OVERCURRENT_FLAG, 8'h00);
      #1;
      `CHK(irq, 1'b1)
      `CHK(det_en, 4'h0)
      wr_reg(`OFS_OVERCURRENT_FLAG, 8'hFF);
      #1;
      `CHK(irq, 1'b0)
      rd_reg(`OFS_OVERCURRENT_FLAG, 8'h00);
    end
    summarize();
  end
endmodule
bind port_pin_config_overcurrent port_pin_config_overcurrent_chk #(.PIN_COUNT(PIN_COUNT))
  chk_u (.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN),
  .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
  .PERIPH_DIGITAL_USE_IN(PERIPH_DIGITAL_USE_IN), .PIN_IS_OUTPUT_IN(PIN_IS_OUTPUT_IN),
  .INPUT_BUFFER_EN_OUT(INPUT_BUFFER_EN_OUT), .REDUCED_DRIVE_OUT(REDUCED_DRIVE_OUT),
  .HIGH_DRIVE_OFF_OUT(HIGH_DRIVE_OFF_OUT), .PAD_O_OUT(PAD_O_OUT), .PAD_OE_OUT(PAD_OE_OUT),
  .SUPPLY_DETECT_EN_OUT(SUPPLY_DETECT_EN_OUT), .HS_PIN5_DETECT_EN_OUT(HS_PIN5_DETECT_EN_OUT),
  .HS_PIN3_DETECT_EN_OUT(HS_PIN3_DETECT_EN_OUT), .HS_PIN1_DETECT_EN_OUT(HS_PIN1_DETECT_EN_OUT),
  .IRQ_OUT(IRQ_OUT));
`default_nettype wire
